// ===== design/atic_ctrl.sv
module atic_ctrl (
    input  wire logic                                i_clock,      // 20 MHz
    input  wire logic                                i_resetn,     // async
    input  wire atic_pkg::atic_xreq_t                i_xreq,       // mcu bus
    output logic      [7:0]                          o_xrdata,     // read
    output atic_pkg::atic_cfg_t                      o_cfg,        // config
    output logic                                     o_drive_reset_pin_n,
    output logic                                     o_engine_reset, // pulse
    output logic      [7:0]                          o_devhead,    // dev/head
    output logic                                     o_devhead_wr, // strobe
    output logic                                     o_cmd_issue,  // strobe
    output logic                                     o_xfer_active, // level
    output logic                                     o_busy,       // level
    input  wire logic                                i_xfer_done,  // engine
    input  wire logic                                i_buf_wr_en,  // push
    input  wire logic [atic_pkg::ATIC_BUF_WIDTH-1:0] i_buf_wr_data,
    input  wire logic                                i_buf_rd_en,  // pop
    output logic      [atic_pkg::ATIC_BUF_WIDTH-1:0] o_buf_rd_data,
    output logic                                     o_buf_rd_valid,
    output logic      [atic_pkg::ATIC_PTR_W:0]       o_buf_count   // fill
);
    import atic_pkg::*;

    logic [1:0]  rst_sync_ff;
    logic        rst_n;
    logic [7:0]  ctrl_ff;
    logic [7:0]  nxt_ctrl;
    logic [7:0]  xrdata_ff;
    logic        pin_n_ff;
    logic        hit_wr;
    logic        hit_rd;
    logic        soft_rst;
    logic        launch;
    atic_state_t state_ff;
    atic_state_t nxt_state;
    logic [7:0]  devhead_ff;
    logic        devhead_wr_ff;
    logic        cmd_issue_ff;
    logic        busy_ff;

    function automatic logic addr_hit(input logic [15:0] addr);
        addr_hit = (addr == ATIC_CTRL_ONE_ADDR);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////
    // control register
    assign hit_wr   = i_xreq.wr && addr_hit(i_xreq.addr);
    assign hit_rd   = i_xreq.rd && addr_hit(i_xreq.addr);
    assign soft_rst = ctrl_ff[ATIC_BIT_SOFT_RESET];
    assign launch   = ctrl_ff[ATIC_BIT_LAUNCH];

    always_comb begin
        nxt_ctrl = ctrl_ff;
        // self-clearing bits drop after their single active cycle
        nxt_ctrl[ATIC_BIT_SOFT_RESET] = 1'b0;
        nxt_ctrl[ATIC_BIT_LAUNCH]     = 1'b0;
        if (hit_wr) begin
            nxt_ctrl = i_xreq.wdata;
            // a rewrite during the pulse cannot stretch it
            nxt_ctrl[ATIC_BIT_SOFT_RESET] =
                i_xreq.wdata[ATIC_BIT_SOFT_RESET] && !soft_rst;
            nxt_ctrl[ATIC_BIT_LAUNCH] =
                i_xreq.wdata[ATIC_BIT_LAUNCH] && !launch;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= ATIC_CTRL_ONE_RESET;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            xrdata_ff <= 8'h00;
        end else begin
            xrdata_ff <= hit_rd ? ctrl_ff : 8'h00;
        end
    end

    // drive reset pin follows only the hard reset bit
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_n_ff <= 1'b1;
        end else begin
            pin_n_ff <= !nxt_ctrl[ATIC_BIT_HARD_RESET];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // protocol sequencer
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ATIC_ST_IDLE: begin
                if (launch) begin
                    nxt_state = ctrl_ff[ATIC_BIT_AUTO_COMMAND] ?
                                ATIC_ST_DEVHEAD : ATIC_ST_XFER;
                end
            end
            ATIC_ST_DEVHEAD: begin
                nxt_state = ATIC_ST_CMD;
            end
            ATIC_ST_CMD: begin
                nxt_state = ctrl_ff[ATIC_BIT_NO_DATA_COMMAND] ?
                            ATIC_ST_DONE : ATIC_ST_XFER;
            end
            ATIC_ST_XFER: begin
                if (i_xfer_done) begin
                    nxt_state = ATIC_ST_DONE;
                end
            end
            ATIC_ST_DONE: begin
                nxt_state = ATIC_ST_IDLE;
            end
            default: begin
                nxt_state = ATIC_ST_IDLE;
            end
        endcase
        if (soft_rst) begin
            nxt_state = ATIC_ST_IDLE;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ATIC_ST_IDLE;
            busy_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            busy_ff  <= (nxt_state != ATIC_ST_IDLE);
        end
    end

    // device/head write carries the drive bit ahead of the command
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            devhead_ff    <= 8'h00;
            devhead_wr_ff <= 1'b0;
            cmd_issue_ff  <= 1'b0;
        end else begin
            devhead_wr_ff <= (nxt_state == ATIC_ST_DEVHEAD);
            cmd_issue_ff  <= (nxt_state == ATIC_ST_CMD);
            if (nxt_state == ATIC_ST_DEVHEAD) begin
                devhead_ff <= 8'h00;
                devhead_ff[ATIC_DEVHEAD_DEV_BIT] <=
                    ctrl_ff[ATIC_BIT_DRIVE_SELECT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    atic_sector_buf u_buf (
        .i_clock    (i_clock),
        .i_rst_n    (rst_n),
        .i_clear    (soft_rst),
        .i_wr_en    (i_buf_wr_en),
        .i_wr_data  (i_buf_wr_data),
        .i_rd_en    (i_buf_rd_en),
        .o_rd_data  (o_buf_rd_data),
        .o_rd_valid (o_buf_rd_valid),
        .o_count    (o_buf_count)
    );

    assign o_xrdata            = xrdata_ff;
    assign o_drive_reset_pin_n = pin_n_ff;
    assign o_engine_reset      = soft_rst;
    assign o_devhead           = devhead_ff;
    assign o_devhead_wr        = devhead_wr_ff;
    assign o_cmd_issue         = cmd_issue_ff;
    assign o_xfer_active       = state_ff[3];
    assign o_busy              = busy_ff;
    assign o_cfg = '{
        packet_protocol_select: ctrl_ff[ATIC_BIT_PACKET_PROTOCOL],
        transfer_direction:     ctrl_ff[ATIC_BIT_DIRECTION],
        auto_command:           ctrl_ff[ATIC_BIT_AUTO_COMMAND],
        no_data_command:        ctrl_ff[ATIC_BIT_NO_DATA_COMMAND],
        drive_select:           ctrl_ff[ATIC_BIT_DRIVE_SELECT]
    };

    ////////////////////////////////////////////////////////////////////////
    property p_soft_idle;
        @(posedge i_clock) disable iff (!rst_n)
        soft_rst |=> (state_ff == ATIC_ST_IDLE) && !o_busy;
    endproperty
    a_soft_idle: assert property (p_soft_idle)
        else $error("sequencer not idle after soft reset");

    property p_soft_one_cycle;
        @(posedge i_clock) disable iff (!rst_n)
        $rose(soft_rst) |=> !soft_rst;
    endproperty
    a_soft_one_cycle: assert property (p_soft_one_cycle)
        else $error("soft reset pulse longer than one cycle");

    property p_soft_reads_zero;
        @(posedge i_clock) disable iff (!rst_n)
        soft_rst ##1 hit_rd |=> !xrdata_ff[ATIC_BIT_SOFT_RESET];
    endproperty
    a_soft_reads_zero: assert property (p_soft_reads_zero)
        else $error("soft reset bit read back as one");

    property p_soft_pin;
        @(posedge i_clock) disable iff (!rst_n)
        (soft_rst && !hit_wr) |=> $stable(pin_n_ff);
    endproperty
    a_soft_pin: assert property (p_soft_pin)
        else $error("soft reset moved the drive reset pin");

    property p_dev_before_cmd;
        @(posedge i_clock) disable iff (!rst_n)
        (state_ff == ATIC_ST_DEVHEAD) |-> devhead_wr_ff ##1
        (cmd_issue_ff && devhead_ff[ATIC_DEVHEAD_DEV_BIT]
            == $past(ctrl_ff[ATIC_BIT_DRIVE_SELECT], 2)) or soft_rst[*1];
    endproperty
    a_dev_before_cmd: assert property (p_dev_before_cmd)
        else $error("drive bit not written before packet command");

    property p_launch;
        @(posedge i_clock) disable iff (!rst_n)
        (launch && !soft_rst && state_ff == ATIC_ST_IDLE) |=>
            !launch
            && (state_ff == ($past(ctrl_ff[ATIC_BIT_AUTO_COMMAND]) ?
                ATIC_ST_DEVHEAD : ATIC_ST_XFER));
    endproperty
    a_launch: assert property (p_launch)
        else $error("launch did not start the right phase");

endmodule // atic_ctrl

// ===== design/atic_sector_buf.sv
module atic_sector_buf (
    input  wire logic                                i_clock,     // clock
    input  wire logic                                i_rst_n,     // reset
    input  wire logic                                i_clear,     // soft clear
    input  wire logic                                i_wr_en,     // push
    input  wire logic [atic_pkg::ATIC_BUF_WIDTH-1:0] i_wr_data,   // push data
    input  wire logic                                i_rd_en,     // pop
    output logic      [atic_pkg::ATIC_BUF_WIDTH-1:0] o_rd_data,   // pop data
    output logic                                     o_rd_valid,  // data ok
    output logic      [atic_pkg::ATIC_PTR_W:0]       o_count      // fill
);
    import atic_pkg::*;

    logic [ATIC_BUF_WIDTH-1:0] mem_ff [ATIC_BUF_DEPTH];
    logic [ATIC_PTR_W-1:0]     wptr_ff;
    logic [ATIC_PTR_W-1:0]     rptr_ff;
    logic [ATIC_PTR_W:0]       count_ff;
    logic [ATIC_BUF_WIDTH-1:0] rd_data_ff;
    logic                      rd_valid_ff;
    logic                      push;
    logic                      pop;

    assign push = i_wr_en && (count_ff != ATIC_COUNT_FULL);
    assign pop  = i_rd_en && (count_ff != ATIC_COUNT_ZERO);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clock) begin
        if (push && !i_clear) begin
            mem_ff[wptr_ff] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wptr_ff <= ATIC_PTR_ZERO;
            rptr_ff <= ATIC_PTR_ZERO;
        end else if (i_clear) begin
            wptr_ff <= ATIC_PTR_ZERO;
            rptr_ff <= ATIC_PTR_ZERO;
        end else begin
            if (push) begin
                wptr_ff <= wptr_ff + 3'h1;
            end
            if (pop) begin
                rptr_ff <= rptr_ff + 3'h1;
            end
        end
    end

    // held words are discarded by dropping the count and the output word
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_ff    <= ATIC_COUNT_ZERO;
            rd_valid_ff <= 1'b0;
            rd_data_ff  <= '0;
        end else if (i_clear) begin
            count_ff    <= ATIC_COUNT_ZERO;
            rd_valid_ff <= 1'b0;
            rd_data_ff  <= '0;
        end else begin
            count_ff    <= count_ff + {3'h0, push} - {3'h0, pop};
            rd_valid_ff <= pop;
            if (pop) begin
                rd_data_ff <= mem_ff[rptr_ff];
            end
        end
    end

    assign o_rd_data  = rd_data_ff;
    assign o_rd_valid = rd_valid_ff;
    assign o_count    = count_ff;

    ////////////////////////////////////////////////////////////////////////
    property p_clear_ptrs;
        @(posedge i_clock) disable iff (!i_rst_n)
        i_clear |=> (wptr_ff == ATIC_PTR_ZERO) && (rptr_ff == ATIC_PTR_ZERO);
    endproperty
    a_clear_ptrs: assert property (p_clear_ptrs)
        else $error("buffer pointers not zero after clear");

    property p_clear_data;
        @(posedge i_clock) disable iff (!i_rst_n)
        i_clear |=> (count_ff == ATIC_COUNT_ZERO) && !rd_valid_ff
                    && (rd_data_ff == '0);
    endproperty
    a_clear_data: assert property (p_clear_data)
        else $error("buffer still holds data after clear");

endmodule // atic_sector_buf

// ===== include/atic_pkg.sv
package atic_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [15:0] ATIC_CTRL_ONE_ADDR  = 16'hf0d1;
    localparam logic [7:0]  ATIC_CTRL_ONE_RESET = 8'h00;

    // ata_interface_control_one field positions
    localparam int ATIC_BIT_DRIVE_SELECT    = 0;
    localparam int ATIC_BIT_NO_DATA_COMMAND = 1;
    localparam int ATIC_BIT_LAUNCH          = 2;
    localparam int ATIC_BIT_AUTO_COMMAND    = 3;
    localparam int ATIC_BIT_DIRECTION       = 4;
    localparam int ATIC_BIT_HARD_RESET      = 5;
    localparam int ATIC_BIT_SOFT_RESET      = 6;
    localparam int ATIC_BIT_PACKET_PROTOCOL = 7;

    // drive bit inside the device/head register
    localparam int ATIC_DEVHEAD_DEV_BIT = 4;

    ////////////////////////////////////////////////////////////////////////
    // sector buffer geometry
    localparam int ATIC_BUF_WIDTH = 16;
    localparam int ATIC_BUF_DEPTH = 8;
    localparam int ATIC_PTR_W     = 3;
    localparam logic [ATIC_PTR_W-1:0] ATIC_PTR_ZERO  = 3'h0;
    localparam logic [ATIC_PTR_W:0]   ATIC_COUNT_ZERO = 4'h0;
    localparam logic [ATIC_PTR_W:0]   ATIC_COUNT_FULL = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [4:0] {
        ATIC_ST_IDLE    = 5'b00001,
        ATIC_ST_DEVHEAD = 5'b00010,
        ATIC_ST_CMD     = 5'b00100,
        ATIC_ST_XFER    = 5'b01000,
        ATIC_ST_DONE    = 5'b10000
    } atic_state_t;

    // microcontroller data-memory access, same clock as the block
    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } atic_xreq_t;

    // configuration carried out to the protocol engine
    typedef struct packed {
        logic packet_protocol_select;
        logic transfer_direction;
        logic auto_command;
        logic no_data_command;
        logic drive_select;
    } atic_cfg_t;

endpackage

// ===== tb/atic_drive_model.sv
module atic_drive_model (
    input  wire logic       i_clock,        // device clock
    input  wire logic       i_resetn,       // async, active low
    input  wire logic       i_xfer_active,  // transfer phase from block
    input  wire logic [7:0] i_delay,        // cycles before completion
    output logic            o_xfer_done     // one-cycle completion pulse
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] wait_ff;

    ////////////////////////////////////////////////////////////////////////
    // completes a transfer after a set number of cycles; a larger delay
    // leaves room to abort the transfer from the register side
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            wait_ff     <= 8'h00;
            o_xfer_done <= 1'b0;
        end else if (i_xfer_active && !o_xfer_done) begin
            o_xfer_done <= (wait_ff == i_delay);
            wait_ff     <= (wait_ff == i_delay) ? 8'h00 : wait_ff + 8'h01;
        end else begin
            o_xfer_done <= 1'b0;
            wait_ff     <= 8'h00;
        end
    end
endmodule // atic_drive_model

// ===== tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import atic_pkg::*;

    logic                  i_clock = 1'b0;
    logic                  i_resetn;
    atic_xreq_t            xreq;
    logic [7:0]            xrdata;
    atic_cfg_t             cfg;
    logic                  pin_n;
    logic                  eng_rst;
    logic [7:0]            devhead;
    logic                  devhead_wr;
    logic                  cmd_issue;
    logic                  xfer_active;
    logic                  busy;
    logic                  xfer_done;
    logic                  buf_wr_en;
    logic [15:0]           buf_wr_data;
    logic                  buf_rd_en;
    logic [15:0]           rd_data;
    logic                  rd_valid;
    logic [ATIC_PTR_W:0]   count;
    logic [7:0]            model_delay;
    int                    failures;
    int                    samples_checked;
    int                    cycle_count;
    time                   bus_last;
    time                   buf_last;

    always #25 i_clock = ~i_clock;

    atic_ctrl dut_u (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_xreq(xreq),
        .o_xrdata(xrdata), .o_cfg(cfg), .o_drive_reset_pin_n(pin_n),
        .o_engine_reset(eng_rst), .o_devhead(devhead),
        .o_devhead_wr(devhead_wr), .o_cmd_issue(cmd_issue),
        .o_xfer_active(xfer_active), .o_busy(busy),
        .i_xfer_done(xfer_done), .i_buf_wr_en(buf_wr_en),
        .i_buf_wr_data(buf_wr_data), .i_buf_rd_en(buf_rd_en),
        .o_buf_rd_data(rd_data), .o_buf_rd_valid(rd_valid),
        .o_buf_count(count)
    );

    atic_drive_model model_u (
        .i_clock(i_clock), .i_resetn(i_resetn),
        .i_xfer_active(xfer_active), .i_delay(model_delay),
        .o_xfer_done(xfer_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // shared tasks, entered at a falling edge except finish_test when called from the hang guard on a rising edge
    task automatic finish_test;
        if (failures == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic acc(input logic w, input logic r,
                       input logic [15:0] a, input logic [7:0] d);
        // an idle cycle keeps a strobe from being dropped and raised at once
        if (bus_last == $time) begin
            @(negedge i_clock);
        end
        xreq.addr  = a;
        xreq.wr    = w;
        xreq.rd    = r;
        xreq.wdata = d;
        @(negedge i_clock);
        xreq.wr  = 1'b0;
        xreq.rd  = 1'b0;
        bus_last = $time;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        acc(1'b1, 1'b0, a, d);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        acc(1'b0, 1'b1, a, 8'h00);
        chk(16'(xrdata), 16'(exp));
    endtask

    task automatic push(input logic [15:0] d);
        if (buf_last == $time) begin
            @(negedge i_clock);
        end
        buf_wr_en   = 1'b1;
        buf_wr_data = d;
        @(negedge i_clock);
        buf_wr_en = 1'b0;
        buf_last  = $time;
    endtask

    task automatic pop;
        buf_rd_en = 1'b1;
        @(negedge i_clock);
        buf_rd_en = 1'b0;
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 20) begin
            @(negedge i_clock);
            n++;
        end
        chk(16'(busy), 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset_values;
        rd_chk(ATIC_CTRL_ONE_ADDR, ATIC_CTRL_ONE_RESET);
        chk(16'(pin_n), 16'h0001);
        chk(16'(count), 16'h0000);
    endtask

    task automatic t_fields_and_hard_reset;
        wr(ATIC_CTRL_ONE_ADDR, 8'h91);
        chk(16'(cfg), 16'h0019);
        rd_chk(ATIC_CTRL_ONE_ADDR, 8'h91);
        wr(16'hf0d2, 8'hff);
        rd_chk(16'hf0d2, 8'h00);
        rd_chk(ATIC_CTRL_ONE_ADDR, 8'h91);
        wr(ATIC_CTRL_ONE_ADDR, 8'h20);
        chk(16'(pin_n), 16'h0000);
        wr(ATIC_CTRL_ONE_ADDR, 8'h00);
        chk(16'(pin_n), 16'h0001);
    endtask

    task automatic t_soft_reset_buffer;
        push(16'h00a1);
        push(16'h00b2);
        push(16'h00c3);
        chk(16'(count), 16'h0003);
        wr(ATIC_CTRL_ONE_ADDR, 8'h40);
        chk(16'(eng_rst), 16'h0001);
        chk(16'(pin_n), 16'h0001);
        @(negedge i_clock);
        chk(16'(eng_rst), 16'h0000);
        chk(16'(count), 16'h0000);
        chk(16'(pin_n), 16'h0001);
        pop;
        chk(16'(rd_valid), 16'h0000);
        push(16'h1234);
        pop;
        chk(rd_data, 16'h1234);
        rd_chk(ATIC_CTRL_ONE_ADDR, 8'h00);
    endtask

    task automatic t_launch_command;
        model_delay = 8'h03;
        wr(ATIC_CTRL_ONE_ADDR, 8'h0d);
        @(negedge i_clock);
        chk(16'(devhead_wr), 16'h0001);
        chk(16'(devhead), 16'h0010);
        chk(16'(cmd_issue), 16'h0000);
        @(negedge i_clock);
        chk(16'(cmd_issue), 16'h0001);
        chk(16'(devhead_wr), 16'h0000);
        @(negedge i_clock);
        chk(16'(xfer_active), 16'h0001);
        wait_idle;
        rd_chk(ATIC_CTRL_ONE_ADDR, 8'h09);
    endtask

    task automatic t_launch_no_data;
        wr(ATIC_CTRL_ONE_ADDR, 8'h0e);
        @(negedge i_clock);
        chk(16'(devhead), 16'h0000);
        @(negedge i_clock);
        chk(16'(cmd_issue), 16'h0001);
        @(negedge i_clock);
        chk(16'(xfer_active), 16'h0000);
        wait_idle;
    endtask

    task automatic t_soft_reset_abort;
        model_delay = 8'h28;
        wr(ATIC_CTRL_ONE_ADDR, 8'h04);
        @(negedge i_clock);
        chk(16'(xfer_active), 16'h0001);
        chk(16'(devhead_wr), 16'h0000);
        wr(ATIC_CTRL_ONE_ADDR, 8'h40);
        chk(16'(eng_rst), 16'h0001);
        @(negedge i_clock);
        chk(16'(busy), 16'h0000);
        chk(16'(xfer_active), 16'h0000);
        chk(16'(pin_n), 16'h0001);
        rd_chk(ATIC_CTRL_ONE_ADDR, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // hang guard, far above the roughly sixty cycles the run needs
    always @(posedge i_clock) begin
        cycle_count++;
        if (cycle_count == 3000) begin
            failures++;
            finish_test();
        end
    end

    initial begin
        i_resetn    = 1'b0;
        xreq        = '0;
        buf_wr_en   = 1'b0;
        buf_wr_data = 16'h0000;
        buf_rd_en   = 1'b0;
        model_delay = 8'h03;
        bus_last    = 0;
        buf_last    = 0;
        repeat (6) @(negedge i_clock);
        i_resetn = 1'b1;
        repeat (3) @(negedge i_clock);
        t_reset_values();
        t_fields_and_hard_reset();
        t_soft_reset_buffer();
        t_launch_command();
        t_launch_no_data();
        t_soft_reset_abort();
        finish_test();
    end
endmodule // tb
